// ### hw/spi_out_pkg.sv
package spi_out_pkg;

  // ------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned IDX_W = 4;
  localparam logic [CNT_W-1:0] FRAME_LEN = 5'h10;
  localparam logic [CNT_W-1:0] CNT_SAT = 5'h11;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [IDX_W-1:0] IDX_ONE = 4'h1;
  localparam logic [IDX_W-1:0] IDX_ZERO = 4'h0;
  localparam logic RW_WRITE = 1'b1;
  localparam logic RW_READ = 1'b0;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [ADDR_W-1:0] addr;
    logic rw;
  } frame_t;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int unsigned NUM_CTRL = 4;
  localparam int unsigned IGN_IDX = 3;
  localparam int unsigned IGN_W = 4;
  localparam logic [NUM_CTRL-1:0][ADDR_W-1:0] CTRL_ADDR = {7'h7E, 7'h7D, 7'h7C, 7'h7B};
  localparam logic [NUM_CTRL-1:0][DATA_W-1:0] CTRL_MASK = {8'h0F, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_COMM_DIAG = 7'h40;
  localparam logic [ADDR_W-1:0] ADDR_MAIN_DIAG = 7'h41;
  localparam logic [ADDR_W-1:0] ADDR_OP_STATUS = 7'h42;
  localparam logic [ADDR_W-1:0] ADDR_FWD_STATUS = 7'h43;
  localparam int unsigned CF_BIT = 0;
  localparam int unsigned COT_BIT = 1;
  localparam int unsigned FRAME_ERR_BIT = 0;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam logic [1:0] STRAP_DELAY = 2'h2;
  localparam logic [1:0] STRAP_ZERO = 2'h0;
  localparam logic [1:0] STRAP_ONE = 2'h1;

  typedef enum logic [1:0] {
    REPLY_REG,
    REPLY_OP_STATUS,
    REPLY_FWD_STATUS,
    REPLY_MAIN_DIAG
  } reply_kind_t;

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic seq_meta;
    logic seq_sync;
    logic seq_seen;
    logic clk_neg_meta;
    logic clk_neg_sync;
    logic sin_neg_meta;
    logic sin_neg_sync;
    logic [1:0] strap_wait;
    logic strap_done;
    logic spi_mode;
    logic oe;
    logic flag;
    logic wd_prev;
    logic wd_hold;
    reply_kind_t reply_kind;
    frame_t reply;
    logic [NUM_CTRL-1:0][DATA_W-1:0] ctrl;
    logic frame_err;
  } state_t;

endpackage : spi_out_pkg

// ### hw/spi_slave_output_control.sv
// Behaviour
// R01: spi mode only when negative clock strap high and negative data strap low
// R02: master sends every command frame least significant bit first
// R03: reply frame shifted out on serial output least significant bit first
// R04: input sampled on falling clock edge, output updated on rising edge
// R05: master ends every access with chip select rising
// R06: frames not exactly 16 bits are dropped and set frame error flag
// R07: reply to a frame is sent during the following frame
// R08: valid write replies rw one, address and register content
// R09: valid read replies rw zero, address and register content
// R10: anything but permitted read or write changes no register
// R11: master issues no multiple-read commands; they count as invalid
// R12: no transmission validity monitoring in spi mode
// R13: before first rising clock, output shows central failure or overtemperature
// R14: during power-on reset frames ignored and output high impedance
// R15: first frame after power-on reset returns operating status register
// R16: during watchdog reset frames ignored, output shows status flag
// R17: first frame after watchdog reset returns watchdog status register; if wd_reset_i falls inside a frame, the reply to that frame wins
// R18: unknown address or wrong access mode returns zero data
// R19: invalid frame makes next reply main diagnosis and sets frame error
// R20: first control register bits 0-7 switch outputs 1-8, reset 0
// R21: second control register bits 0-7 switch outputs 9-16, reset 0
// R22: third control register bits 0-7 switch outputs 17-24, reset 0
// R23: ignition register bits 0-3 switch ignition outputs 1-4, reset 0
// R24: frame holds rw in bit 0, address in 7:1, data in 15:8
// R25: command rw one is write, zero is read
`timescale 1ns/100ps
`default_nettype none

module spi_slave_output_control (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic serial_clock_pos_i,
  input wire logic chip_select_n_i,
  input wire logic serial_in_pos_i,
  input wire logic serial_clock_neg_i,
  input wire logic serial_in_neg_i,
  input wire logic wd_reset_i,
  input wire logic frame_error_clr_i,
  input wire logic [7:0] operating_status_i,
  input wire logic [7:0] func_watchdog_status_i,
  input wire logic [7:0] main_diag_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic spi_mode_o,
  output logic frame_error_flag_o,
  output logic [7:0] out_on_low_o,
  output logic [7:0] out_on_mid_o,
  output logic [7:0] out_on_high_o,
  output logic [3:0] ignition_on_o
);

  // ------------------------------------------------------------
  // link side: receive on falling edge
  // ------------------------------------------------------------
  logic [spi_out_pkg::FRAME_BITS-1:0] rx_shift_q;
  logic [spi_out_pkg::CNT_W-1:0] bit_cnt_q;
  logic [spi_out_pkg::CNT_W-1:0] frame_len_q;
  logic seq_q;
  logic [spi_out_pkg::IDX_W-1:0] tx_idx_q;
  logic tx_started_q;
  logic tx_bit_q;
  spi_out_pkg::state_t q;
  spi_out_pkg::state_t d;

  // bit counter restarts whenever the chip is deselected
  always_ff @(negedge serial_clock_pos_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      bit_cnt_q <= spi_out_pkg::CNT_ZERO;
    end else if (bit_cnt_q != spi_out_pkg::CNT_SAT) begin
      bit_cnt_q <= bit_cnt_q + spi_out_pkg::CNT_ONE;
    end
  end

  // data, length and a per-frame toggle survive deselect for the system side
  always_ff @(negedge serial_clock_pos_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_shift_q <= 16'h0000;
      frame_len_q <= spi_out_pkg::CNT_ZERO;
      seq_q <= 1'b0;
    end else begin
      rx_shift_q <= {serial_in_pos_i, rx_shift_q[spi_out_pkg::FRAME_BITS-1:1]}; // R02 R04
      frame_len_q <= (bit_cnt_q == spi_out_pkg::CNT_SAT) ? spi_out_pkg::CNT_SAT
                                                         : bit_cnt_q + spi_out_pkg::CNT_ONE;
      if (bit_cnt_q == spi_out_pkg::CNT_ZERO) begin
        seq_q <= ~seq_q;
      end
    end
  end

  // ------------------------------------------------------------
  // link side: transmit on rising edge
  // ------------------------------------------------------------
  always_ff @(posedge serial_clock_pos_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      tx_idx_q <= spi_out_pkg::IDX_ZERO;
      tx_started_q <= 1'b0;
    end else begin
      tx_idx_q <= tx_idx_q + spi_out_pkg::IDX_ONE;
      tx_started_q <= 1'b1;
    end
  end

  // reply word is held still by the system side while chip select is low
  always_ff @(posedge serial_clock_pos_i) begin
    tx_bit_q <= q.reply[tx_idx_q]; // R03 R04 R07
  end

  // status flag until the first rising edge, and for the whole frame in watchdog reset
  assign serial_out_o = (tx_started_q && !q.wd_hold) ? tx_bit_q : q.flag; // R13 R16
  assign serial_out_oe_o = q.oe; // R14

  // ------------------------------------------------------------
  // system side
  // ------------------------------------------------------------
  always_comb begin
    spi_out_pkg::frame_t cmd;
    logic frame_end;
    logic frame_start;
    logic valid;
    logic hit_ctrl;
    logic [spi_out_pkg::DATA_W-1:0] rdata;
    d = q;
    cmd = rx_shift_q; // R24
    hit_ctrl = 1'b0;
    rdata = spi_out_pkg::DATA_ZERO;
    frame_end = 1'b0;
    frame_start = 1'b0;
    valid = 1'b0;

    d.cs_meta = chip_select_n_i;
    d.cs_sync = q.cs_meta;
    d.cs_prev = q.cs_sync;
    d.seq_meta = seq_q;
    d.seq_sync = q.seq_meta;
    d.clk_neg_meta = serial_clock_neg_i;
    d.clk_neg_sync = q.clk_neg_meta;
    d.sin_neg_meta = serial_in_neg_i;
    d.sin_neg_sync = q.sin_neg_meta;

    // strap pins are caught once, after the synchronisers have filled
    if (!q.strap_done) begin
      if (q.strap_wait == spi_out_pkg::STRAP_DELAY) begin
        d.strap_done = 1'b1;
        d.spi_mode = q.clk_neg_sync && !q.sin_neg_sync; // R01
      end else begin
        d.strap_wait = q.strap_wait + spi_out_pkg::STRAP_ONE;
      end
    end
    d.oe = d.spi_mode; // R14

    d.flag = main_diag_i[spi_out_pkg::CF_BIT] | main_diag_i[spi_out_pkg::COT_BIT]; // R13
    d.wd_prev = wd_reset_i;
    d.wd_hold = wd_reset_i; // R16
    if (q.wd_prev && !wd_reset_i) begin
      d.reply_kind = spi_out_pkg::REPLY_FWD_STATUS; // R17
    end

    if (frame_error_clr_i) begin
      d.frame_err = 1'b0;
    end

    frame_start = !q.cs_sync && q.cs_prev;
    frame_end = q.cs_sync && !q.cs_prev && q.spi_mode && !wd_reset_i; // R05 R16
    if (frame_start) begin
      d.seq_seen = q.seq_sync;
    end
    // only the bit count is checked; no further validity monitoring
    valid = (q.seq_sync != q.seq_seen) && (frame_len_q == spi_out_pkg::FRAME_LEN); // R06 R12

    if (frame_end) begin
      if (!valid) begin
        d.frame_err = 1'b1; // R06 R19
        d.reply_kind = spi_out_pkg::REPLY_MAIN_DIAG; // R19
      end else begin
        d.reply_kind = spi_out_pkg::REPLY_REG;
        for (int i = 0; i < spi_out_pkg::NUM_CTRL; i++) begin
          if (cmd.addr == spi_out_pkg::CTRL_ADDR[i]) begin
            hit_ctrl = 1'b1;
            if (cmd.rw == spi_out_pkg::RW_WRITE) begin
              d.ctrl[i] = cmd.data & spi_out_pkg::CTRL_MASK[i]; // R20 R21 R22 R23 R25
            end
            rdata = d.ctrl[i]; // R08 R09
          end
        end
        // status registers are read only: a write returns zero and changes nothing
        if (!hit_ctrl && cmd.rw == spi_out_pkg::RW_READ) begin
          unique case (cmd.addr)
            spi_out_pkg::ADDR_COMM_DIAG: rdata[spi_out_pkg::FRAME_ERR_BIT] = q.frame_err;
            spi_out_pkg::ADDR_MAIN_DIAG: rdata = main_diag_i;
            spi_out_pkg::ADDR_OP_STATUS: rdata = operating_status_i;
            spi_out_pkg::ADDR_FWD_STATUS: rdata = func_watchdog_status_i;
            default: rdata = spi_out_pkg::DATA_ZERO; // R10 R18
          endcase
        end
        d.reply.rw = cmd.rw; // R08 R09
        d.reply.addr = cmd.addr;
        d.reply.data = rdata;
      end
    end

    // special replies track live content until the next frame begins
    if (q.cs_sync && !frame_end) begin
      unique case (d.reply_kind)
        spi_out_pkg::REPLY_OP_STATUS: begin
          d.reply = {operating_status_i, spi_out_pkg::ADDR_OP_STATUS, spi_out_pkg::RW_READ}; // R15
        end
        spi_out_pkg::REPLY_FWD_STATUS: begin
          d.reply = {func_watchdog_status_i, spi_out_pkg::ADDR_FWD_STATUS, spi_out_pkg::RW_READ}; // R17
        end
        spi_out_pkg::REPLY_MAIN_DIAG: begin
          d.reply = {main_diag_i, spi_out_pkg::ADDR_MAIN_DIAG, spi_out_pkg::RW_READ}; // R19
        end
        spi_out_pkg::REPLY_REG: begin
          d.reply = q.reply;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      q <= '0;
      q.cs_meta <= 1'b1;
      q.cs_sync <= 1'b1;
      q.cs_prev <= 1'b1;
      q.strap_wait <= spi_out_pkg::STRAP_ZERO;
      q.reply_kind <= spi_out_pkg::REPLY_OP_STATUS; // R15
      q.ctrl <= {spi_out_pkg::NUM_CTRL{spi_out_pkg::CTRL_RESET}}; // R20 R21 R22 R23
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign spi_mode_o = q.spi_mode;
  assign frame_error_flag_o = q.frame_err;
  assign out_on_low_o = q.ctrl[0];
  assign out_on_mid_o = q.ctrl[1];
  assign out_on_high_o = q.ctrl[2];
  assign ignition_on_o = q.ctrl[spi_out_pkg::IGN_IDX][spi_out_pkg::IGN_W-1:0];

endmodule : spi_slave_output_control

`default_nettype wire

// ### testbench/spi_out_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module spi_out_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic chip_select_n_i,
  input wire logic serial_clock_neg_i,
  input wire logic serial_in_neg_i,
  input wire logic wd_reset_i,
  input wire logic frame_error_clr_i,
  input wire logic [7:0] main_diag_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o,
  input wire logic spi_mode_o,
  input wire logic frame_error_flag_o,
  input wire logic [7:0] out_on_low_o,
  input wire logic [3:0] ignition_on_o
);
  logic st;
  assign st = main_diag_i[0] | main_diag_i[1];
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_oe_rst; disable iff (1'b0) !rst_b_i |=> !serial_out_oe_o; endproperty
  property p_ctl_rst; disable iff (1'b0) !rst_b_i |=> out_on_low_o == 8'h00 && ignition_on_o == 4'h0; endproperty
  property p_ctl_cs; $changed({out_on_low_o, ignition_on_o}) |-> chip_select_n_i && $past(chip_select_n_i, 2); endproperty
  property p_err_cs; $rose(frame_error_flag_o) |-> chip_select_n_i; endproperty
  property p_err_hold; frame_error_flag_o && !frame_error_clr_i |=> frame_error_flag_o; endproperty
  property p_wd_hold; wd_reset_i && $past(wd_reset_i, 4) |-> $stable({out_on_low_o, ignition_on_o}); endproperty
  property p_wd_out; wd_reset_i && $past(wd_reset_i, 3) && !chip_select_n_i |-> serial_out_o == st; endproperty
  property p_strap; $rose(spi_mode_o) |-> serial_clock_neg_i && !serial_in_neg_i; endproperty
  property p_flag; $fell(chip_select_n_i) && serial_out_oe_o |-> ##2 serial_out_o == st; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("output driven in reset");
  a_ctl_rst: assert property (p_ctl_rst) else $error("control not cleared by reset");
  a_ctl_cs: assert property (p_ctl_cs) else $error("control changed inside a frame");
  a_err_cs: assert property (p_err_cs) else $error("frame error set inside a frame");
  a_err_hold: assert property (p_err_hold) else $error("frame error lost");
  a_wd_hold: assert property (p_wd_hold) else $error("control changed in watchdog reset");
  a_wd_out: assert property (p_wd_out) else $error("serial out not status in watchdog reset");
  a_strap: assert property (p_strap) else $error("spi mode without strap");
  a_flag: assert property (p_flag) else $error("status level missing at frame start");
  c_write: cover property ($changed(out_on_low_o));
  c_err: cover property ($rose(frame_error_flag_o));
  c_wd: cover property (wd_reset_i && !chip_select_n_i);
endmodule : spi_out_asserts
bind spi_slave_output_control spi_out_asserts i_spi_out_asserts (.*);
`default_nettype wire

// ### testbench/spi_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
  input wire logic miso_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // clock stands low outside frames; flag is the level before the first clock
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx, output logic flag);
    rx = 16'h0000;
    cs_n_o = 1'b0;
    #110;
    flag = miso_i;
    for (int k = 0; k < n; k++) begin
      sclk_o = 1'b1;
      mosi_o = tx[k];
      #24;
      sclk_o = 1'b0;
      rx[k] = miso_i;
      #24;
    end
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #200;
  endtask : xfer
endmodule : spi_master_model
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic sys_clk_i, rst_b_i, serial_clock_pos_i, chip_select_n_i, serial_in_pos_i, serial_clock_neg_i;
  logic serial_in_neg_i, wd_reset_i, frame_error_clr_i, serial_out_o, serial_out_oe_o, spi_mode_o;
  logic frame_error_flag_o, miso, flg, st;
  logic [7:0] operating_status_i, func_watchdog_status_i, main_diag_i, out_on_low_o, out_on_mid_o, out_on_high_o;
  logic [3:0] ignition_on_o;
  logic [15:0] rx, want;
  logic [31:0] outs;
  int fail_count, checks_done;
  localparam logic [7:0] VAL [4] = '{8'hA5, 8'h5A, 8'hC3, 8'hFF};
  assign miso = serial_out_oe_o ? serial_out_o : 1'bz;
  assign st = main_diag_i[0] | main_diag_i[1];
  spi_slave_output_control i_spi_slave_output_control (.*);
  spi_master_model i_spi_master_model (.miso_i(miso), .sclk_o(serial_clock_pos_i), .cs_n_o(chip_select_n_i),
    .mosi_o(serial_in_pos_i));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [15:0] fw(input logic [7:0] d, input logic [6:0] a, input logic r);
    return {d, a, r};
  endfunction : fw
  task automatic outs_ok(input string what);
    @(negedge sys_clk_i);
    check(what, {ignition_on_o, out_on_high_o, out_on_mid_o, out_on_low_o}, outs);
  endtask : outs_ok
  // one frame; the reply seen belongs to the frame before
  task automatic xf(input logic [15:0] tx, input int n, input logic [15:0] nxt);
    i_spi_master_model.xfer(tx, n, rx, flg);
    check("reply", rx & (16'hFFFF >> (16 - n)), want & (16'hFFFF >> (16 - n)));
    check("status level", flg, st);
    want = nxt;
  endtask : xf
  task automatic do_reset();
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    check("drive in reset", serial_out_oe_o, 1'b0);
    rst_b_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    outs = 32'h0;
    outs_ok("reset values");
    want = fw(operating_status_i, 7'h42, 1'b0);
  endtask : do_reset
  task automatic t_strap();
    serial_in_neg_i <= 1'b1;
    do_reset();
    check("mode off", {spi_mode_o, serial_out_oe_o}, 2'b00);
    serial_in_neg_i <= 1'b0;
    do_reset();
    check("mode on", {spi_mode_o, serial_out_oe_o}, 2'b11);
  endtask : t_strap
  task automatic t_regs();
    logic [6:0] a;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      a = spi_out_pkg::CTRL_ADDR[i];
      d = VAL[i] & spi_out_pkg::CTRL_MASK[i];
      outs[i*8 +: 8] = d;
      xf(fw(VAL[i], a, 1'b1), 16, fw(d, a, 1'b1));
      outs_ok("switch outputs");
      xf(fw(8'h00, a, 1'b0), 16, fw(d, a, 1'b0));
      xf(fw(8'h00, 7'h7F, 1'b0), 16, fw(8'h00, 7'h7F, 1'b0));
    end
  endtask : t_regs
  task automatic t_invalid();
    @(posedge sys_clk_i);
    main_diag_i <= 8'h01;
    xf(fw(8'h00, 7'h7B, 1'b1), 15, fw(8'h01, 7'h41, 1'b0));
    outs_ok("short frame");
    check("frame error", frame_error_flag_o, 1'b1);
    xf(fw(8'h12, 7'h42, 1'b1), 16, fw(8'h00, 7'h42, 1'b1));
    @(posedge sys_clk_i);
    frame_error_clr_i <= 1'b1;
    @(posedge sys_clk_i);
    frame_error_clr_i <= 1'b0;
    repeat (2) @(negedge sys_clk_i);
    check("frame error clear", frame_error_flag_o, 1'b0);
    xf(fw(8'h00, 7'h40, 1'b0), 16, fw(8'h00, 7'h40, 1'b0));
  endtask : t_invalid
  task automatic t_watchdog();
    @(posedge sys_clk_i);
    wd_reset_i <= 1'b1;
    main_diag_i <= 8'h02;
    repeat (5) @(posedge sys_clk_i);
    want = 16'hFFFF;
    xf(fw(8'h00, 7'h7B, 1'b1), 16, fw(func_watchdog_status_i, 7'h43, 1'b0));
    outs_ok("watchdog ignore");
    @(posedge sys_clk_i);
    wd_reset_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    xf(fw(8'h00, 7'h7C, 1'b0), 16, fw(outs[15:8], 7'h7C, 1'b0));
    xf(fw(8'h00, 7'h7E, 1'b0), 16, fw(outs[31:24], 7'h7E, 1'b0));
  endtask : t_watchdog
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
  initial begin
    {rst_b_i, serial_clock_neg_i, serial_in_neg_i, wd_reset_i, frame_error_clr_i} = 5'b01000;
    {operating_status_i, func_watchdog_status_i, main_diag_i} = 24'h9C3602;
    t_strap();
    t_regs();
    t_invalid();
    t_watchdog();
    do_reset();
    xf(fw(8'h00, 7'h7D, 1'b0), 16, fw(8'h00, 7'h7D, 1'b0));
    xf(fw(8'h00, 7'h7E, 1'b0), 16, 16'h0000);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
